// file: txac_pkg.sv
// Constants, register map and carrier types for the transmit attenuation controller.
// Assumes one 100 MHz clock and a plain register port driven from the same clock.
//
// What this block does
// - Holds a 960-row attenuation table; only rows 0 to 839 are ever selected.
// - Each index adds 0.05 dB, giving 41.95 dB at the last used row, 839.
// - Total attenuation is the analog part plus the digital part of one row.
// - Analog step word is 6 bits, 64 linear steps, 20log10(1-word/64) dB.
// - A 12-bit digital multiplier fills the gaps between analog steps.
// - Analog part stays within 36 dB and digital part within 6 dB.
// - Direct FM limits attenuation to 12 dB in 0.5 dB steps.
// - Digital gain is word/4096, except word 4095 gives exactly one.
// - A stored row holds only the analog word and the digital word.
// - Digital word 2053..4095 in a 16-bit field, 8-bit analog, 8-bit reserved.
// - Modes are bypass 0, serial write 1, pin control 3, closed loop 4.
// - Bypass applies zero attenuation.
// - Serial mode takes host-written targets, with TDD ramp or constant-step option.
// - Constant-step ramps at once toward a new target by step and wait.
// - TDD ramp moves between programmed on and off levels by step and wait.
// - Pin mode increments or decrements the index by a configured step.
// - Outside bypass, the power monitor drives attenuation through this block while overloaded.

package txac_pkg;

    localparam int TBL_ENTRIES = 960;

    localparam logic [9:0]  TBL_LAST_W   = 10'h3BF;
    localparam logic [9:0]  IDX_MAX      = 10'h347;
    localparam logic [9:0]  DFM_IDX_MAX  = 10'hF0;
    localparam logic [9:0]  DFM_IDX_STEP = 10'h00A;
    localparam logic [9:0]  STEP_DEF     = 10'h001;

    localparam logic [11:0] MULT_UNITY   = 12'hFFF;
    localparam logic [11:0] MULT_MIN     = 12'h805;
    localparam logic [12:0] GAIN_ONE     = 13'h1000;
    localparam logic [5:0]  ANALOG_MAX   = 6'h3F;
    localparam int          GAIN_SHIFT   = 12;

    localparam logic [2:0]  MODE_BYPASS  = 3'h0;
    localparam logic [2:0]  MODE_SERIAL  = 3'h1;
    localparam logic [2:0]  MODE_PIN     = 3'h3;
    localparam logic [2:0]  MODE_CLOSED_LOOP_GAIN_MODE    = 3'h4;

    localparam logic [7:0]  ADDR_MODE     = 8'h00;
    localparam logic [7:0]  ADDR_CFG      = 8'h04;
    localparam logic [7:0]  ADDR_TARGET   = 8'h08;
    localparam logic [7:0]  ADDR_STEP     = 8'h0C;
    localparam logic [7:0]  ADDR_WAIT     = 8'h10;
    localparam logic [7:0]  ADDR_TDD_ON   = 8'h14;
    localparam logic [7:0]  ADDR_TDD_OFF  = 8'h18;
    localparam logic [7:0]  ADDR_TDD_CMD  = 8'h1C;
    localparam logic [7:0]  ADDR_PIN_STEP = 8'h20;
    localparam logic [7:0]  ADDR_TBL_ADDR = 8'h24;
    localparam logic [7:0]  ADDR_TBL_DATA = 8'h28;
    localparam logic [7:0]  ADDR_STATUS   = 8'h2C;

    localparam int CFG_CONST_BIT  = 0;
    localparam int CFG_DFM_BIT    = 1;
    localparam int CMD_UP_BIT     = 0;
    localparam int CMD_DOWN_BIT   = 1;
    localparam int STAT_BUSY_BIT  = 16;
    localparam int STAT_PM_BIT    = 17;

    localparam logic [15:0] WAIT_DEF = 16'h0000;

    typedef struct packed {
        logic [7:0]  rsvd;
        logic [7:0]  analog;
        logic [15:0] mult;
    } txac_row_t;

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } txac_iq_t;

    typedef struct packed {
        logic [2:0]  mode;
        logic        const_opt;
        logic        dfm;
        logic [9:0]  tgt;
        logic [9:0]  idx;
        logic [9:0]  step;
        logic [9:0]  pin_step;
        logic [9:0]  tdd_on;
        logic [9:0]  tdd_off;
        logic [9:0]  tbl_addr;
        logic [15:0] wait_len;
        logic [15:0] cnt;
        logic        pm_seen;
        logic [31:0] rdata;
        logic [5:0]  analog;
        logic [11:0] dgain;
        txac_iq_t    iq;
    } txac_state_t;

endpackage

// file: txac_edge_sync.sv
// Two-flop synchroniser with a rising-edge pulse for one external pin.
// Assumes the pin is asynchronous to clk_sys and holds each level for two cycles or more.

`timescale 1ns/1ps

module txac_edge_sync (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      rise_pulse
);

    logic [2:0] sync_r;
    logic [2:0] sync_nxt;

    always_comb begin
        sync_nxt = {sync_r[1:0], pin_in};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_r <= 3'h0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    // One pulse per rising edge, seen only after the second flop.
    assign rise_pulse = sync_r[1] & ~sync_r[2];

endmodule

// file: txac_top.sv
// Transmit attenuation controller: table, mode control, ramp engine and digital gain.
// Assumes a host on the register port and pin, closed-loop and monitor inputs.
//
// The register addresses and the plain strobed port were left to the implementer.

`timescale 1ns/1ps

module txac_top (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    input  wire logic              pin_inc,
    input  wire logic              pin_dec,
    input  wire logic [9:0]        closed_loop_gain_mode_index,
    input  wire logic              pm_overload,
    input  wire txac_pkg::txac_iq_t iq_in,
    output txac_pkg::txac_iq_t     iq_out,
    output logic [5:0]             analog_step_word,
    output logic [11:0]            digital_gain_word,
    output logic [9:0]             atten_index,
    output logic                   ramp_busy
);

    import txac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State, table and pin edges.

    txac_state_t s_r;
    txac_state_t s_nxt;
    txac_row_t   tbl_mem [0:TBL_ENTRIES-1];
    txac_row_t   wr_row;
    txac_row_t   use_row;
    txac_row_t   rd_row;
    logic        tbl_we;
    logic        inc_p;
    logic        dec_p;
    logic [9:0]  eff_idx;
    logic [9:0]  eff_step;
    logic [9:0]  up_gap;
    logic [9:0]  dn_gap;
    logic [12:0] gain13;
    logic signed [29:0] prod_i;
    logic signed [29:0] prod_q;
    logic        ramp_on;

    txac_edge_sync u_sync_inc (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_in     (pin_inc),
        .rise_pulse (inc_p)
    );

    txac_edge_sync u_sync_dec (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_in     (pin_dec),
        .rise_pulse (dec_p)
    );

    function automatic logic [9:0] clamp_idx(input logic [9:0] v);
        clamp_idx = (v > IDX_MAX) ? IDX_MAX : v;
    endfunction

    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m == MODE_BYPASS) || (m == MODE_SERIAL) ||
                  (m == MODE_PIN) || (m == MODE_CLOSED_LOOP_GAIN_MODE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Table rows: only the two control words are stored.

    always_comb begin
        wr_row = '0;
        if (reg_wdata[15:0] > {4'h0, MULT_UNITY}) begin
            wr_row.mult = {4'h0, MULT_UNITY};
        end else if (reg_wdata[15:0] < {4'h0, MULT_MIN}) begin
            wr_row.mult = {4'h0, MULT_MIN};
        end else begin
            wr_row.mult = reg_wdata[15:0];
        end
        if (reg_wdata[23:16] > {2'h0, ANALOG_MAX}) begin
            wr_row.analog = {2'h0, ANALOG_MAX};
        end else begin
            wr_row.analog = reg_wdata[23:16];
        end
    end

    assign tbl_we = reg_wr && (reg_addr == ADDR_TBL_DATA) && (s_r.tbl_addr <= TBL_LAST_W);

    always_ff @(posedge clk_sys) begin
        if (tbl_we) begin
            tbl_mem[s_r.tbl_addr] <= wr_row;
        end
    end

    // Direct FM keeps to 12 dB in 0.5 dB steps.
    always_comb begin
        eff_idx = s_r.idx;
        if (s_r.dfm) begin
            eff_idx = (s_r.idx > DFM_IDX_MAX) ? DFM_IDX_MAX : s_r.idx;
            eff_idx = eff_idx - (eff_idx % DFM_IDX_STEP);
        end
    end

    // Each index is a further 0.05 dB, made of an analog and a digital part.
    assign use_row  = tbl_mem[eff_idx];
    assign rd_row   = tbl_mem[(s_r.tbl_addr <= TBL_LAST_W) ? s_r.tbl_addr : 10'h000];
    assign eff_step = (s_r.step == 10'h000) ? STEP_DEF : s_r.step;
    assign up_gap   = s_r.tgt - s_r.idx;
    assign dn_gap   = s_r.idx - s_r.tgt;
    assign ramp_on  = (s_r.mode == MODE_SERIAL) || (pm_overload && s_r.mode != MODE_BYPASS);

    // Word 4095 means exact unity; otherwise gain is word/4096.
    assign gain13 = (s_r.dgain == MULT_UNITY) ? GAIN_ONE : {1'b0, s_r.dgain};
    assign prod_i = iq_in.i * $signed({1'b0, gain13});
    assign prod_q = iq_in.q * $signed({1'b0, gain13});

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        s_nxt       = s_r;
        s_nxt.rdata = 32'h0000_0000;

        if (reg_wr) begin
            case (reg_addr)
                ADDR_MODE: begin
                    if (mode_ok(reg_wdata[2:0])) begin
                        s_nxt.mode = reg_wdata[2:0];
                    end
                end
                ADDR_CFG: begin
                    s_nxt.const_opt = reg_wdata[CFG_CONST_BIT];
                    s_nxt.dfm       = reg_wdata[CFG_DFM_BIT];
                end
                ADDR_TARGET: begin
                    if (s_r.const_opt) begin
                        s_nxt.tgt = clamp_idx(reg_wdata[9:0]);
                    end
                end
                ADDR_STEP:     s_nxt.step     = reg_wdata[9:0];
                ADDR_WAIT:     s_nxt.wait_len = reg_wdata[15:0];
                ADDR_TDD_ON:   s_nxt.tdd_on   = clamp_idx(reg_wdata[9:0]);
                ADDR_TDD_OFF:  s_nxt.tdd_off  = clamp_idx(reg_wdata[9:0]);
                ADDR_TDD_CMD: begin
                    if (!s_r.const_opt && reg_wdata[CMD_UP_BIT]) begin
                        s_nxt.tgt = s_r.tdd_on;
                    end else if (!s_r.const_opt && reg_wdata[CMD_DOWN_BIT]) begin
                        s_nxt.tgt = s_r.tdd_off;
                    end
                end
                ADDR_PIN_STEP: s_nxt.pin_step = reg_wdata[9:0];
                ADDR_TBL_ADDR: s_nxt.tbl_addr = reg_wdata[9:0];
                ADDR_TBL_DATA: s_nxt.tbl_addr = s_r.tbl_addr + 10'h001;
                ADDR_STATUS: begin
                    if (reg_wdata[STAT_PM_BIT]) begin
                        s_nxt.pm_seen = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                ADDR_MODE:     s_nxt.rdata = {29'h0, s_r.mode};
                ADDR_CFG:      s_nxt.rdata = {30'h0, s_r.dfm, s_r.const_opt};
                ADDR_TARGET:   s_nxt.rdata = {22'h0, s_r.tgt};
                ADDR_STEP:     s_nxt.rdata = {22'h0, s_r.step};
                ADDR_WAIT:     s_nxt.rdata = {16'h0, s_r.wait_len};
                ADDR_TDD_ON:   s_nxt.rdata = {22'h0, s_r.tdd_on};
                ADDR_TDD_OFF:  s_nxt.rdata = {22'h0, s_r.tdd_off};
                ADDR_PIN_STEP: s_nxt.rdata = {22'h0, s_r.pin_step};
                ADDR_TBL_ADDR: s_nxt.rdata = {22'h0, s_r.tbl_addr};
                ADDR_TBL_DATA: s_nxt.rdata = rd_row;
                ADDR_STATUS: begin
                    s_nxt.rdata                = {22'h0, s_r.idx};
                    s_nxt.rdata[STAT_BUSY_BIT] = (s_r.idx != s_r.tgt);
                    s_nxt.rdata[STAT_PM_BIT]   = s_r.pm_seen;
                end
                default:       s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Per-mode index control.
        case (s_r.mode)
            MODE_BYPASS: begin
                s_nxt.idx = 10'h000;
                s_nxt.tgt = 10'h000;
                s_nxt.cnt = 16'h0000;
            end
            MODE_PIN: begin
                if (!pm_overload && inc_p && !dec_p) begin
                    s_nxt.idx = (IDX_MAX - s_r.idx > s_r.pin_step) ?
                                s_r.idx + s_r.pin_step : IDX_MAX;
                end else if (!pm_overload && dec_p && !inc_p) begin
                    s_nxt.idx = (s_r.idx > s_r.pin_step) ?
                                s_r.idx - s_r.pin_step : 10'h000;
                end
                s_nxt.tgt = s_nxt.idx;
            end
            MODE_CLOSED_LOOP_GAIN_MODE: begin
                if (!pm_overload) begin
                    s_nxt.idx = clamp_idx(closed_loop_gain_mode_index);
                    s_nxt.tgt = s_nxt.idx;
                end
            end
            default: ;
        endcase

        // Ramp engine: one step each time the wait count runs out.
        if (ramp_on) begin
            if (s_r.cnt != 16'h0000) begin
                s_nxt.cnt = s_r.cnt - 16'h0001;
            end else if (s_r.idx < s_r.tgt) begin
                s_nxt.idx = (up_gap > eff_step) ? s_r.idx + eff_step : s_r.tgt;
                s_nxt.cnt = s_r.wait_len;
            end else if (s_r.idx > s_r.tgt) begin
                s_nxt.idx = (dn_gap > eff_step) ? s_r.idx - eff_step : s_r.tgt;
                s_nxt.cnt = s_r.wait_len;
            end
        end

        // Outside bypass, the power monitor ramps toward full attenuation while overloaded.
        if (pm_overload && s_r.mode != MODE_BYPASS) begin
            s_nxt.tgt     = IDX_MAX;
            s_nxt.pm_seen = 1'b1;
        end

        // Applied control words and scaled samples.
        if (s_r.mode == MODE_BYPASS) begin
            s_nxt.analog = 6'h00;
            s_nxt.dgain  = MULT_UNITY;
        end else begin
            s_nxt.analog = use_row.analog[5:0];
            s_nxt.dgain  = use_row.mult[11:0];
        end
        s_nxt.iq.i = prod_i[GAIN_SHIFT+15:GAIN_SHIFT];
        s_nxt.iq.q = prod_q[GAIN_SHIFT+15:GAIN_SHIFT];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r          <= '0;
            s_r.step     <= STEP_DEF;
            s_r.pin_step <= STEP_DEF;
            s_r.wait_len <= WAIT_DEF;
            s_r.dgain    <= MULT_UNITY;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata         = s_r.rdata;
    assign iq_out            = s_r.iq;
    assign analog_step_word  = s_r.analog;
    assign digital_gain_word = s_r.dgain;
    assign atten_index       = s_r.idx;
    assign ramp_busy         = (s_r.idx != s_r.tgt);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (rst);

    a_idx_in_range: assert property (s_r.idx <= IDX_MAX)
        else $error("Attenuation index beyond last used row.");

    a_bypass_unity: assert property (
        s_r.mode == MODE_BYPASS |=> analog_step_word == 6'h00 && digital_gain_word == MULT_UNITY)
        else $error("Bypass did not apply zero attenuation.");

    a_unity_gain_pass: assert property (
        digital_gain_word == MULT_UNITY |=> iq_out.i == $past(iq_in.i)
                                           && iq_out.q == $past(iq_in.q))
        else $error("Word 4095 did not give unity gain.");

    a_gain_not_up: assert property (
        digital_gain_word != MULT_UNITY && iq_in.i >= 16'sh0000
        |=> iq_out.i <= $past(iq_in.i))
        else $error("Digital gain raised a positive sample.");

    a_row_clamped: assert property (tbl_we |-> wr_row.mult <= {4'h0, MULT_UNITY}
                                          && wr_row.mult >= {4'h0, MULT_MIN}
                                          && wr_row.analog <= {2'h0, ANALOG_MAX})
        else $error("Table row written outside its limits.");

    a_dfm_limit: assert property (
        s_r.dfm |-> eff_idx <= DFM_IDX_MAX && (eff_idx % DFM_IDX_STEP) == 10'h000)
        else $error("Direct FM index beyond 12 dB or off the 0.5 dB grid.");

    a_pin_step_up: assert property (
        s_r.mode == MODE_PIN && !pm_overload && inc_p && !dec_p
        && (IDX_MAX - s_r.idx > s_r.pin_step)
        |=> atten_index == $past(s_r.idx) + $past(s_r.pin_step))
        else $error("Pin increment did not add one step.");

    a_pin_saturate: assert property (
        s_r.mode == MODE_PIN && !pm_overload && dec_p && !inc_p
        && s_r.idx <= s_r.pin_step |=> atten_index == 10'h000)
        else $error("Pin decrement did not stop at zero.");

    a_edge_single: assert property (inc_p |=> !inc_p)
        else $error("Pin edge produced more than one step.");

    a_const_ramp: assert property (
        s_r.mode == MODE_SERIAL && !pm_overload && s_r.cnt == 16'h0000
        && s_r.idx < s_r.tgt && up_gap > eff_step
        |=> atten_index == $past(s_r.idx) + $past(eff_step) && s_r.cnt == $past(s_r.wait_len))
        else $error("Ramp step or wait reload wrong.");

    a_ramp_holds: assert property (
        s_r.mode == MODE_SERIAL && s_r.cnt != 16'h0000 |=> $stable(atten_index))
        else $error("Index moved during the wait between steps.");

    a_monitor_force: assert property (
        pm_overload && s_r.mode != MODE_BYPASS |=> s_r.tgt == IDX_MAX && s_r.pm_seen)
        else $error("Power monitor did not drive full attenuation.");

    c_pin_inc:   cover property (s_r.mode == MODE_PIN && inc_p ##1 atten_index != 10'h000);
    c_const_end: cover property (s_r.mode == MODE_SERIAL && s_r.const_opt && ramp_busy
                                 ##1 !ramp_busy);
    c_tdd_up:    cover property (s_r.mode == MODE_SERIAL && !s_r.const_opt
                                 && s_r.tgt == s_r.tdd_on && ramp_busy);
    c_pm_max:    cover property (pm_overload ##1 atten_index == IDX_MAX);

endmodule

// file: txac_bb_model.sv
// Baseband model for the attenuation controller: register master and two step pins.
// Assumes the controller samples its register port on the rising edge of clk_sys.

`timescale 1ns/1ps

module txac_bb_model (
    input  wire logic        clk_sys,
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata,
    output logic             pin_inc,
    output logic             pin_dec
);

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        pin_inc   = 1'b0;
        pin_dec   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Released address and data lines show the inverse of the last value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // One rising edge per call on the chosen pin, held for hold cycles.
    task automatic pin_pulse(input logic up, input int hold);
        if (up) begin
            pin_inc <= 1'b1;
        end else begin
            pin_dec <= 1'b1;
        end
        repeat (hold) @(posedge clk_sys);
        pin_inc <= 1'b0;
        pin_dec <= 1'b0;
        repeat (hold) @(posedge clk_sys);
    endtask

endmodule

// file: testbench.sv
// Self-checking testbench for the transmit attenuation controller.
// Assumes the baseband model drives the register port and the step pins.

`timescale 1ns/1ps

module testbench;
    import txac_pkg::*;

    logic               clk_sys;
    logic               rst;
    logic [7:0]         reg_addr;
    logic [31:0]        reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [31:0]        reg_rdata;
    logic               pin_inc;
    logic               pin_dec;
    logic [9:0]         closed_loop_gain_mode_index;
    logic               pm_overload;
    txac_iq_t           iq_in;
    txac_iq_t           iq_out;
    logic [5:0]         analog_step_word;
    logic [11:0]        digital_gain_word;
    logic [9:0]         atten_index;
    logic               ramp_busy;
    logic [31:0]        d;
    int                 n_errors;
    int                 check_count;

    txac_top u_txac_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_inc(pin_inc), .pin_dec(pin_dec), .closed_loop_gain_mode_index(closed_loop_gain_mode_index),
        .pm_overload(pm_overload), .iq_in(iq_in), .iq_out(iq_out),
        .analog_step_word(analog_step_word), .digital_gain_word(digital_gain_word),
        .atten_index(atten_index), .ramp_busy(ramp_busy));

    txac_bb_model u_txac_bb_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_inc(pin_inc), .pin_dec(pin_dec));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, closing report and helpers.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic [31:0] row(input int i);
        return {8'h00, 8'(i), 16'(12'hFFF - 12'(16 * i))};
    endfunction

    task automatic settle;
        int k;
        k = 0;
        while (ramp_busy !== 1'b0 && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 200) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, k, 0);
            wrap_up();
        end
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic words(input int i);
        chk(atten_index, i);
        chk(analog_step_word, 6'(i));
        chk(digital_gain_word, 12'hFFF - 12'(16 * i));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset;
        chk(atten_index, 0);
        chk(digital_gain_word, 12'hFFF);
        chk(ramp_busy, 0);
        u_txac_bb_model.rd(ADDR_STEP, d);
        chk(d, 1);
        @(posedge clk_sys);
        chk(reg_rdata, 0);
        $display("reset test done");
    endtask

    task automatic t_table;
        u_txac_bb_model.wr(ADDR_TBL_ADDR, 0);
        for (int i = 0; i < 8; i++) begin
            u_txac_bb_model.wr(ADDR_TBL_DATA, row(i));
        end
        u_txac_bb_model.wr(ADDR_TBL_DATA, 32'hFF4A_0000);
        u_txac_bb_model.wr(ADDR_TBL_ADDR, 8);
        u_txac_bb_model.rd(ADDR_TBL_DATA, d);
        chk(d, 32'h003F_0805);
        u_txac_bb_model.wr(ADDR_TBL_ADDR, 3);
        u_txac_bb_model.rd(ADDR_TBL_DATA, d);
        chk(d, row(3));
        u_txac_bb_model.rd(8'h30, d);
        chk(d, 0);
        $display("table test done");
    endtask

    task automatic t_modes;
        logic [2:0] m[5] = '{3'h2, MODE_SERIAL, MODE_PIN, MODE_CLOSED_LOOP_GAIN_MODE, MODE_BYPASS};
        logic [2:0] e[5] = '{MODE_BYPASS, MODE_SERIAL, MODE_PIN, MODE_CLOSED_LOOP_GAIN_MODE, MODE_BYPASS};
        for (int i = 0; i < 5; i++) begin
            u_txac_bb_model.wr(ADDR_MODE, 32'(m[i]));
            u_txac_bb_model.rd(ADDR_MODE, d);
            chk(d[2:0], e[i]);
        end
        $display("mode test done");
    endtask

    task automatic t_const_step;
        int last;
        logic [9:0] prev;
        u_txac_bb_model.wr(ADDR_CFG, 1);
        u_txac_bb_model.wr(ADDR_STEP, 2);
        u_txac_bb_model.wr(ADDR_WAIT, 3);
        u_txac_bb_model.wr(ADDR_MODE, 32'(MODE_SERIAL));
        u_txac_bb_model.wr(ADDR_TARGET, 5);
        prev = 0;
        last = -1;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_sys);
            if (atten_index !== prev) begin
                chk(atten_index, (prev + 2 > 5) ? 5 : prev + 2);
                if (last >= 0) chk(k - last, 4);
                last = k;
                prev = atten_index;
            end
        end
        settle();
        words(5);
        $display("constant step test done");
    endtask

    task automatic t_tdd;
        u_txac_bb_model.wr(ADDR_CFG, 0);
        u_txac_bb_model.wr(ADDR_TDD_ON, 7);
        u_txac_bb_model.wr(ADDR_TDD_OFF, 1);
        u_txac_bb_model.wr(ADDR_TDD_CMD, 1);
        settle();
        words(7);
        u_txac_bb_model.wr(ADDR_TARGET, 3);
        settle();
        chk(atten_index, 7);
        u_txac_bb_model.wr(ADDR_TDD_CMD, 2);
        settle();
        words(1);
        $display("tdd test done");
    endtask

    task automatic t_dfm;
        u_txac_bb_model.wr(ADDR_TBL_ADDR, 32'h0F0);
        u_txac_bb_model.wr(ADDR_TBL_DATA, 32'h0021_0900);
        u_txac_bb_model.wr(ADDR_CFG, 3);
        u_txac_bb_model.wr(ADDR_STEP, 32'h3FF);
        u_txac_bb_model.wr(ADDR_TARGET, 32'h007);
        settle();
        chk(atten_index, 10'h007);
        chk({analog_step_word, digital_gain_word}, 18'h00FFF);
        u_txac_bb_model.wr(ADDR_TARGET, 32'h3FF);
        settle();
        chk(atten_index, 10'h347);
        chk({analog_step_word, digital_gain_word}, {6'h21, 12'h900});
        u_txac_bb_model.wr(ADDR_CFG, 0);
        $display("direct fm test done");
    endtask

    task automatic t_pin;
        logic [9:0] st[6] = '{10'h3FF, 10'h3FF, 10'h001, 10'h001, 10'h3FF, 10'h3FF};
        logic       up[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        logic [9:0] ex[6] = '{10'h000, 10'h000, 10'h001, 10'h002, 10'h347, 10'h347};
        u_txac_bb_model.wr(ADDR_MODE, 32'(MODE_PIN));
        for (int i = 0; i < 6; i++) begin
            u_txac_bb_model.wr(ADDR_PIN_STEP, 32'(st[i]));
            u_txac_bb_model.pin_pulse(up[i], 3 + i);
            repeat (2) @(posedge clk_sys);
            chk(atten_index, ex[i]);
        end
        $display("pin test done");
    endtask

    task automatic t_closed_loop_gain_mode;
        u_txac_bb_model.wr(ADDR_MODE, 32'(MODE_CLOSED_LOOP_GAIN_MODE));
        closed_loop_gain_mode_index <= 10'h3FF;
        repeat (4) @(posedge clk_sys);
        chk(atten_index, 10'h347);
        closed_loop_gain_mode_index <= 10'h003;
        repeat (4) @(posedge clk_sys);
        words(3);
        chk(iq_out.i, 16'((int'(iq_in.i) * int'(12'hFCF)) >>> 12));
        chk(iq_out.q, 16'((int'(iq_in.q) * int'(12'hFCF)) >>> 12));
        $display("closed loop test done");
    endtask

    task automatic t_pm;
        u_txac_bb_model.wr(ADDR_CFG, 1);
        u_txac_bb_model.wr(ADDR_MODE, 32'(MODE_SERIAL));
        u_txac_bb_model.wr(ADDR_TARGET, 0);
        settle();
        pm_overload <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk(atten_index, 10'h347);
        u_txac_bb_model.rd(ADDR_STATUS, d);
        chk(d, 32'h0002_0347);
        pm_overload <= 1'b0;
        u_txac_bb_model.wr(ADDR_STATUS, 32'h0002_0000);
        u_txac_bb_model.rd(ADDR_STATUS, d);
        chk(d[17], 1'b0);
        $display("power monitor test done");
    endtask

    task automatic t_bypass;
        u_txac_bb_model.wr(ADDR_MODE, 32'(MODE_BYPASS));
        repeat (3) @(posedge clk_sys);
        chk(atten_index, 0);
        chk(analog_step_word, 0);
        chk(digital_gain_word, 12'hFFF);
        chk(iq_out, iq_in);
        $display("bypass test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        n_errors = 0;
        check_count = 0;
        rst = 1'b1;
        closed_loop_gain_mode_index = 10'h000;
        pm_overload = 1'b0;
        iq_in = 32'h3A5C_C1E7;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_table();
        t_modes();
        t_const_step();
        t_tdd();
        t_dfm();
        t_pin();
        t_closed_loop_gain_mode();
        t_pm();
        t_bypass();
        wrap_up();
    end

endmodule
